// ### core/acs_chain_ctrl.v
// acs_chain_ctrl.v: status bytes and masked-write chain control register of
// the measurement acquisition chain.
// assumes: a synchronous register port on clk_sys from the internal global
// address space; conversion events come from logic on the same clock; the
// shunt-open comparator level arrives asynchronously.
`timescale 1ns/10ps
`default_nettype none
`include "acs_defs.vh"
module acs_chain_ctrl (
    input wire clk_sys,
    input wire rst_n,
    input wire regSel,
    input wire regWr,
    input wire regWord,
    input wire [11:0] regAddr,
    input wire [15:0] regWdata,
    output reg [15:0] regRdata_q,
    output reg regAck_q,
    input wire shuntOpenRaw,
    input wire normalMode,
    input wire shunt_detect_enable,
    input wire voltStrobe,
    input wire [15:0] voltResult,
    input wire currStrobe,
    input wire voltRead,
    input wire currRead,
    input wire extTempStrobe,
    input wire intTempStrobe,
    input wire gainChangeStrobe,
    input wire [2:0] manual_gain_field,
    input wire [2:0] autoGain,
    output reg temp_compensation_enable,
    output reg volt_compensation_enable,
    output reg curr_compensation_enable,
    output reg lowpass_enable,
    output reg ext_temp_chopper,
    output reg int_temp_chopper,
    output reg volt_curr_chopper_enable,
    output reg auto_gain_enable,
    output reg [2:0] currGain_q
);
    // ----------------------------------------------------------------
    // address decode
    // ----------------------------------------------------------------
    wire [11:0] baseBlk;
    wire [11:0] baseNonBlk;
    wire inWindow;
    wire hitStatHi;
    wire hitStatLo;
    wire hitCtrl;
    wire wrStatHi;
    wire wrCtrl;
    // blocking and non-blocking windows alias onto the same registers
    assign baseBlk = `ACS_BASE_BLOCKING;
    assign baseNonBlk = `ACS_BASE_NONBLOCKING;
    assign inWindow = ({regAddr[11:8], 8'h00} == baseBlk) ||
                      ({regAddr[11:8], 8'h00} == baseNonBlk);
    assign hitStatHi = inWindow && (regAddr[7:0] == `ACS_OFS_STAT_HI);
    assign hitStatLo = inWindow && (regAddr[7:0] == `ACS_OFS_STAT_LO);
    assign hitCtrl = inWindow && (regAddr[7:0] == `ACS_OFS_CTRL1);
    assign wrStatHi = regSel && regWr && hitStatHi;
    assign wrCtrl = regSel && regWr && hitCtrl && regWord;

    // ----------------------------------------------------------------
    // shunt-open level synchroniser
    // ----------------------------------------------------------------
    reg openMeta_q;
    reg openSync_q;
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            openMeta_q <= 1'b0;
            openSync_q <= 1'b0;
        end else begin
            openMeta_q <= shuntOpenRaw;
            openSync_q <= openMeta_q;
        end
    end

    // ----------------------------------------------------------------
    // chain control register
    // ----------------------------------------------------------------
    reg [7:0] ctrl_q;
    reg [7:0] ctrl_d;
    // each lower bit follows write data only where its mask bit is set
    always @* begin
        ctrl_d = ctrl_q;
        if (wrCtrl) begin
            ctrl_d = (ctrl_q & ~regWdata[15:8]) | (regWdata[7:0] & regWdata[15:8]);
        end
    end
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_q <= `ACS_CTRL1_RESET;
        end else begin
            ctrl_q <= ctrl_d;
        end
    end

    // control outputs registered from the next value so they track ctrl_q
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            temp_compensation_enable <= 1'b1;
            volt_compensation_enable <= 1'b1;
            curr_compensation_enable <= 1'b1;
            lowpass_enable <= 1'b0;
            ext_temp_chopper <= 1'b0;
            int_temp_chopper <= 1'b0;
            volt_curr_chopper_enable <= 1'b0;
            auto_gain_enable <= 1'b1;
            currGain_q <= 3'h0;
        end else begin
            temp_compensation_enable <= ctrl_d[`ACS_CTL_TEMP_COMPENSATION_ENABLE];
            volt_compensation_enable <= ctrl_d[`ACS_CTL_VOLT_COMPENSATION_ENABLE];
            curr_compensation_enable <= ctrl_d[`ACS_CTL_CURR_COMPENSATION_ENABLE];
            lowpass_enable <= ctrl_d[`ACS_CTL_LPF];
            ext_temp_chopper <= ctrl_d[`ACS_CTL_ETCH];
            int_temp_chopper <= ctrl_d[`ACS_CTL_ITCH];
            volt_curr_chopper_enable <= ctrl_d[`ACS_CTL_CVCH];
            auto_gain_enable <= ctrl_d[`ACS_CTL_AUTO_GAIN_ENABLE];
            currGain_q <= ctrl_d[`ACS_CTL_AUTO_GAIN_ENABLE] ? autoGain : manual_gain_field;
        end
    end

    // ----------------------------------------------------------------
    // voltage threshold and pending-result tracking
    // ----------------------------------------------------------------
    reg voltHigh_q;
    reg voltPending_q;
    reg currPending_q;
    // threshold compared on each new voltage result
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            voltHigh_q <= 1'b0;
            voltPending_q <= 1'b0;
            currPending_q <= 1'b0;
        end else begin
            if (voltStrobe) begin
                voltHigh_q <= (voltResult >= `ACS_VTH_CODE);
            end
            // a new result re-arms pending even if read in the same cycle
            if (voltStrobe) begin
                voltPending_q <= 1'b1;
            end else if (voltRead) begin
                voltPending_q <= 1'b0;
            end
            if (currStrobe) begin
                currPending_q <= 1'b1;
            end else if (currRead) begin
                currPending_q <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // high status flags, write one to clear, polled only (no irq)
    // ----------------------------------------------------------------
    wire [6:0] flagSet;
    wire [6:0] flagVal;
    assign flagSet[`ACS_HI_GAIN] = gainChangeStrobe;
    assign flagSet[`ACS_HI_VOLT_RESULT_OVERWRITTEN] = voltStrobe && voltPending_q && !voltRead;
    assign flagSet[`ACS_HI_CURR_RESULT_OVERWRITTEN] = currStrobe && currPending_q && !currRead;
    assign flagSet[`ACS_HI_ETM] = extTempStrobe;
    assign flagSet[`ACS_HI_ITM] = intTempStrobe;
    assign flagSet[`ACS_HI_VM] = voltStrobe;
    assign flagSet[`ACS_HI_CM] = currStrobe;
    genvar gi;
    generate
        for (gi = 0; gi < 7; gi = gi + 1) begin : gFlag
            acs_sticky_flag uFlag (
                .clk_sys(clk_sys),
                .rst_n(rst_n),
                .setEvt(flagSet[gi]),
                .clrEvt(wrStatHi && regWdata[gi]),
                .flag_q(flagVal[gi])
            );
        end
    endgenerate

    // ----------------------------------------------------------------
    // read data and acknowledge
    // ----------------------------------------------------------------
    reg [15:0] rdata_d;
    wire [7:0] statLo;
    // mode gating of open status left to software, bits 6-5 tied low
    assign statLo = {openSync_q, 2'b00, voltHigh_q, ctrl_q[`ACS_CTL_ETCH],
                     ctrl_q[`ACS_CTL_ITCH], ctrl_q[`ACS_CTL_CVCH],
                     ctrl_q[`ACS_CTL_CVCH]};
    always @* begin
        rdata_d = 16'h0000;
        if (hitStatHi) begin
            rdata_d = {9'h000, flagVal};
        end else if (hitStatLo) begin
            rdata_d = {8'h00, statLo};
        end else if (hitCtrl) begin
            rdata_d = {8'h00, ctrl_q};
        end
    end
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            regRdata_q <= 16'h0000;
            regAck_q <= 1'b0;
        end else begin
            regAck_q <= regSel;
            if (regSel && !regWr) begin
                regRdata_q <= rdata_d;
            end
        end
    end

    // mode inputs kept for the port contract, bit 7 is not gated by them
    wire unusedBits;
    assign unusedBits = normalMode | shunt_detect_enable;
endmodule // acs_chain_ctrl
`default_nettype wire

// ### core/acs_defs.vh
// acs_defs.vh: offsets, field positions, reset values and thresholds of the
// acquisition chain status and control block.
// assumes: included by bare name from the core design files.
`ifndef ACS_DEFS_VH
`define ACS_DEFS_VH

`define ACS_BASE_BLOCKING 12'h200
`define ACS_BASE_NONBLOCKING 12'h300
`define ACS_OFS_STAT_HI 8'h5A
`define ACS_OFS_STAT_LO 8'h5B
`define ACS_OFS_CTRL1 8'h5C

`define ACS_STAT_OPEN 7
`define ACS_STAT_VTH 4
`define ACS_STAT_ETCH 3
`define ACS_STAT_ITCH 2
`define ACS_STAT_VCH 1
`define ACS_STAT_CCH 0

`define ACS_HI_GAIN 6
`define ACS_HI_VOLT_RESULT_OVERWRITTEN 5
`define ACS_HI_CURR_RESULT_OVERWRITTEN 4
`define ACS_HI_ETM 3
`define ACS_HI_ITM 2
`define ACS_HI_VM 1
`define ACS_HI_CM 0

`define ACS_CTL_TEMP_COMPENSATION_ENABLE 7
`define ACS_CTL_VOLT_COMPENSATION_ENABLE 6
`define ACS_CTL_CURR_COMPENSATION_ENABLE 5
`define ACS_CTL_LPF 4
`define ACS_CTL_ETCH 3
`define ACS_CTL_ITCH 2
`define ACS_CTL_CVCH 1
`define ACS_CTL_AUTO_GAIN_ENABLE 0
`define ACS_MASK_SHIFT 8

`define ACS_CTRL1_RESET 8'hE1
`define ACS_STAT_HI_RESET 8'h00
`define ACS_VTH_CODE 16'hDAC0

`endif

// ### core/acs_sticky_flag.v
// acs_sticky_flag.v: one hardware-set, write-one-to-clear flag.
// assumes: set and clear come from logic on clk_sys.
`timescale 1ns/10ps
`default_nettype none
module acs_sticky_flag (
    input wire clk_sys,
    input wire rst_n,
    input wire setEvt,
    input wire clrEvt,
    output reg flag_q
);
    // set wins over a clear in the same cycle
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            flag_q <= 1'b0;
        end else if (setEvt) begin
            flag_q <= 1'b1;
        end else if (clrEvt) begin
            flag_q <= 1'b0;
        end
    end
endmodule // acs_sticky_flag
`default_nettype wire

// ### tb/acs_chain_ctrl_sva.sv
// acs_chain_ctrl_sva.sv: port assertions for the chain control block.
// assumes: bound to acs_chain_ctrl from the bench top; one clock.
`timescale 1ns/10ps
`default_nettype none
module acs_chain_ctrl_sva (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic regSel,
    input wire logic regWr,
    input wire logic regWord,
    input wire logic [11:0] regAddr,
    input wire logic [15:0] regWdata,
    input wire logic [15:0] regRdata_q,
    input wire logic regAck_q,
    input wire logic [2:0] autoGain,
    input wire logic [2:0] manual_gain_field,
    input wire logic temp_compensation_enable,
    input wire logic volt_compensation_enable,
    input wire logic curr_compensation_enable,
    input wire logic lowpass_enable,
    input wire logic ext_temp_chopper,
    input wire logic int_temp_chopper,
    input wire logic volt_curr_chopper_enable,
    input wire logic auto_gain_enable,
    input wire logic [2:0] currGain_q
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    // ---------------------------------------------------------------
    // decoded accesses
    // ---------------------------------------------------------------
    wire logic hit = regSel && (regAddr[11:8] == 4'h2 || regAddr[11:8] == 4'h3);
    wire logic rdLo = hit && !regWr && regAddr[7:0] == 8'h5B;
    wire logic rdCtl = hit && !regWr && regAddr[7:0] == 8'h5C;
    wire logic wrCtl = hit && regWr && regWord && regAddr[7:0] == 8'h5C;
    wire logic [7:0] ctl = {temp_compensation_enable, volt_compensation_enable,
        curr_compensation_enable, lowpass_enable, ext_temp_chopper, int_temp_chopper,
        volt_curr_chopper_enable, auto_gain_enable};
    chk_ack_pulse: assert property (regSel |=> regAck_q)
        else $error("no acknowledge after access");
    chk_ack_drop: assert property (!regSel |=> !regAck_q)
        else $error("acknowledge without access");
    chk_lo_zero: assert property (rdLo |=>
        regRdata_q[15:8] == 8'h00 && regRdata_q[6:5] == 2'b00)
        else $error("reserved status bits not zero");
    chk_lo_chop: assert property (rdLo |=>
        regRdata_q[3:0] == {$past(ctl[3:1]), $past(ctl[1])})
        else $error("chopper status mismatch");
    chk_ctl_read: assert property (rdCtl |=> regRdata_q == {8'h00, $past(ctl)})
        else $error("control read mismatch");
    chk_byte_keep: assert property (regSel && regWr && !regWord |=> $stable(ctl))
        else $error("byte write changed control");
    chk_mask_keep: assert property (wrCtl |=>
        ((ctl ^ $past(ctl)) & ~$past(regWdata[15:8])) == 8'h00)
        else $error("unmasked control bit changed");
    chk_mask_take: assert property (wrCtl |=>
        ((ctl ^ $past(regWdata[7:0])) & $past(regWdata[15:8])) == 8'h00)
        else $error("masked control bit not written");
    // gain output lags the gain inputs by one cycle and changes in the same cycle as the enable it is registered with
    chk_gain_auto: assert property ($past(rst_n) && auto_gain_enable |->
        currGain_q == $past(autoGain))
        else $error("automatic gain not followed");
    chk_gain_manual: assert property ($past(rst_n) && !auto_gain_enable |->
        currGain_q == $past(manual_gain_field))
        else $error("manual gain not followed");
endmodule // acs_chain_ctrl_sva
`default_nettype wire

// ### tb/tb.sv
// tb.sv: self-checking bench for the chain control block.
// assumes: core files compiled first; checker bound below.
`timescale 1ns/10ps
`default_nettype none
module tb;
    logic clk_sys = 0, rst_n = 0, regSel = 0, regWr = 0, regWord = 0, openRaw = 0;
    logic [11:0] regAddr = 12'h000;
    logic [15:0] regWdata = 16'h0000, vRes = 16'h0000, rd;
    logic [6:0] evV = 7'h00;
    logic [2:0] manGain = 3'h5, autoGain = 3'h2;
    wire [15:0] regRdata_q;
    wire regAck_q;
    wire [7:0] outs;
    wire [2:0] currGain_q;
    int n_fail = 0, n_compared = 0, cyc = 0;
    always #4 clk_sys = ~clk_sys;
    acs_chain_ctrl dut (.clk_sys(clk_sys), .rst_n(rst_n), .regSel(regSel), .regWr(regWr),
        .regWord(regWord), .regAddr(regAddr), .regWdata(regWdata), .regRdata_q(regRdata_q),
        .regAck_q(regAck_q), .shuntOpenRaw(openRaw), .normalMode(1'b1),
        .shunt_detect_enable(1'b1), .voltStrobe(evV[5]), .voltResult(vRes),
        .currStrobe(evV[4]), .voltRead(evV[3]), .currRead(evV[2]), .extTempStrobe(evV[1]),
        .intTempStrobe(evV[0]), .gainChangeStrobe(evV[6]), .manual_gain_field(manGain),
        .autoGain(autoGain), .temp_compensation_enable(outs[7]),
        .volt_compensation_enable(outs[6]), .curr_compensation_enable(outs[5]),
        .lowpass_enable(outs[4]), .ext_temp_chopper(outs[3]), .int_temp_chopper(outs[2]),
        .volt_curr_chopper_enable(outs[1]), .auto_gain_enable(outs[0]),
        .currGain_q(currGain_q));
    // compare, register access and event pulse helpers
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic acc(input logic w, input logic wd, input logic [11:0] a, input logic [15:0] d);
        @(negedge clk_sys);
        regSel = 1;
        regWr = w;
        regWord = wd;
        regAddr = a;
        regWdata = d;
        @(negedge clk_sys);
        regSel = 0;
        chk({15'h0000, regAck_q}, 16'h0001);
        rd = regRdata_q;
    endtask
    task automatic ev(input logic [6:0] e);
        @(negedge clk_sys);
        evV = e;
        @(negedge clk_sys);
        evV = 7'h00;
    endtask
    task automatic ctl(input logic [15:0] exp);
        acc(0, 1, 12'h25C, 16'h0000);
        chk(rd, exp);
        chk({8'h00, outs}, {8'h00, exp[7:0]});
    endtask
    // scenarios
    task automatic s_mask;
        ctl(16'h00E1);
        acc(1, 1, 12'h25C, 16'h1010);
        ctl(16'h00F1);
        acc(1, 1, 12'h35C, 16'h0FFF);
        ctl(16'h00FF);
        acc(0, 0, 12'h25B, 16'h0000);
        chk(rd, 16'h000F);
        acc(1, 1, 12'h25C, 16'hF100);
        ctl(16'h000E);
        chk({13'h0000, currGain_q}, {13'h0000, manGain});
        acc(1, 1, 12'h25C, 16'h00FF);
        ctl(16'h000E);
        acc(1, 0, 12'h25C, 16'hFFE1);
        ctl(16'h000E);
        acc(1, 1, 12'h45C, 16'hFFE1);
        acc(0, 1, 12'h45C, 16'h0000);
        chk(rd, 16'h0000);
        acc(1, 1, 12'h25C, 16'hFFE1);
        ctl(16'h00E1);
        chk({13'h0000, currGain_q}, {13'h0000, autoGain});
    endtask
    task automatic s_flags;
        acc(1, 0, 12'h25A, 16'hFFFF);
        ev(7'h60);
        ev(7'h20);
        ev(7'h10);
        ev(7'h04);
        ev(7'h10);
        ev(7'h03);
        acc(0, 0, 12'h35A, 16'h0000);
        chk({8'h00, rd[15:8] | rd[7:0]}, 16'h006F);
        acc(1, 0, 12'h35A, 16'h6060);
        acc(0, 0, 12'h25A, 16'h0000);
        chk({8'h00, rd[15:8] | rd[7:0]}, 16'h000F);
        // gain change and its clear in one cycle: the set must win
        fork
            ev(7'h40);
            acc(1, 0, 12'h25A, 16'h0040);
        join
        acc(0, 0, 12'h25A, 16'h0000);
        chk({8'h00, rd[15:8] | rd[7:0]}, 16'h004F);
    endtask
    task automatic s_stat;
        vRes = 16'hDABF;
        ev(7'h28);
        acc(0, 0, 12'h25B, 16'h0000);
        chk(rd, 16'h0000);
        vRes = 16'hDAC0;
        ev(7'h28);
        acc(0, 0, 12'h25B, 16'h0000);
        chk(rd, 16'h0010);
        openRaw = 1;
        repeat (3) @(negedge clk_sys);
        acc(1, 0, 12'h25B, 16'hFFFF);
        acc(0, 0, 12'h35B, 16'h0000);
        chk(rd, 16'h0090);
    endtask
    task automatic test_done;
        $display("compared %0d, failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // main sequence and hang guard
    initial begin
        repeat (12) @(negedge clk_sys);
        rst_n = 1;
        s_mask();
        s_flags();
        s_stat();
        test_done();
    end
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            n_fail++;
            test_done();
        end
    end
endmodule // tb
bind acs_chain_ctrl acs_chain_ctrl_sva u_sva (.clk_sys(clk_sys), .rst_n(rst_n),
    .regSel(regSel), .regWr(regWr), .regWord(regWord), .regAddr(regAddr),
    .regWdata(regWdata), .regRdata_q(regRdata_q), .regAck_q(regAck_q), .autoGain(autoGain),
    .temp_compensation_enable(temp_compensation_enable), .lowpass_enable(lowpass_enable),
    .volt_compensation_enable(volt_compensation_enable), .auto_gain_enable(auto_gain_enable),
    .curr_compensation_enable(curr_compensation_enable), .int_temp_chopper(int_temp_chopper),
    .ext_temp_chopper(ext_temp_chopper), .volt_curr_chopper_enable(volt_curr_chopper_enable),
    .manual_gain_field(manual_gain_field), .currGain_q(currGain_q));
`default_nettype wire
